// ### hw/exception_priority_vector_logic.sv
// Exception pending/active state, prioritisation and vector addressing.
// Assumes pulses on the request inputs and a core that acknowledges
// the offered exception and reports handler completion.
//
// Summary of operation
// - Vector entry lies at base plus four times exception number.
// - Peripheral n is exception n+16; reserved line numbers are holes.
// - Entry zero of the table holds the boot stack pointer.
// - Table base is zero after reset.
// - Privileged write relocates base between 0x0 and 0x3fffff00.
// - Smaller priority value means more urgent.
// - All but reset, NMI and hard fault have settable priority.
// - Settable priorities reset to zero.
// - Settable priorities are three bits, 0 to 7.
// - Reset, NMI, hard fault always outrank settable exceptions.
// - Equal priority: smallest exception number wins.
// - Arrival with a strictly more urgent group preempts the running handler.
// - Equal priority never preempts; it stays pending.
// - Reset ranks -3, NMI -2, hard fault -1.
// - Preemption compares only the group field.
`timescale 1ns/1ps
module exception_priority_vector_logic
	import exc_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	// Exception requests, one-cycle pulses
	input  wire logic [IRQ_NUM-1:0]   irq_i,
	input  wire logic [SYS_NUM-1:0]   sys_pend_i,
	// Priority configuration
	input  wire logic                 cfg_prio_we_i,
	input  wire logic [5:0]           cfg_prio_num_i,
	input  wire logic [2:0]           cfg_prio_val_i,
	input  wire logic [1:0]           subpri_bits_i,
	// Vector table relocation
	input  wire logic                 vtor_we_i,
	input  wire logic                 vtor_priv_i,
	input  wire logic [31:0]          vtor_val_i,
	// Core handshake
	input  wire logic                 core_ack_i,
	input  wire logic                 exc_done_i,
	input  wire logic [5:0]           exc_done_num_i,
	// Offer to the core
	output logic                      exc_req_o,
	output logic [5:0]                exc_num_o,
	output logic [31:0]               vec_addr_o,
	// Boot entries and status
	output logic [31:0]               boot_sp_addr_o,
	output logic [31:0]               boot_pc_addr_o,
	output logic [31:0]               vector_base_offset_reg_o,
	output logic [EXC_NUM-1:0]        pend_o,
	output logic [EXC_NUM-1:0]        active_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [21:0]        vtor_r;
	logic [2:0]         prio_r [EXC_NUM];
	logic [EXC_NUM-1:0] pend_r;
	logic [EXC_NUM-1:0] act_r;
	logic [EXC_NUM-1:0] pend_nxt;
	logic [EXC_NUM-1:0] act_nxt;
	logic [EXC_NUM-1:0] take_vec;
	logic [EXC_NUM-1:0] done_vec;
	logic               req_r;
	logic               req_nxt;
	logic [5:0]         num_r;
	logic [31:0]        vec_r;
	logic [31:0]        base_w;
	logic [3:0]         grank_w [EXC_NUM];
	logic [3:0]         run_grank;
	logic [3:0]         sel_grank;
	logic               take;
	logic               tie_lower;

	exc_arb_if #(.N(EXC_NUM)) arb ();

	////////////////////////////////////////////////////////////////////////
	// Rank decode, used for full ranking and for group-only ranking
	function automatic logic [3:0] rank_of(
		input logic [5:0] num,
		input logic [2:0] prio,
		input logic [1:0] shr
	);
		logic [2:0] grp;
		grp = prio >> shr;
		unique case (num)
			6'h01:    rank_of = RANK_RESET;
			EXC_NMI:  rank_of = RANK_NMI;
			EXC_HARD: rank_of = RANK_HARD;
			default:  rank_of = RANK_CFG0 + {1'b0, grp};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Table base; low 8 bits dropped since only aligned offsets are legal
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			vtor_r <= VTOR_RST;
		end else if (vtor_we_i && vtor_priv_i) begin
			vtor_r <= vtor_val_i[29:8];
		end
	end

	assign base_w                   = {2'b00, vtor_r, 8'h00};
	assign vector_base_offset_reg_o = base_w;
	// Boot stack pointer at entry zero, boot code at entry one
	assign boot_sp_addr_o           = base_w;
	assign boot_pc_addr_o           = {2'b00, vtor_r, VEC_OFF_PC[7:0]};

	////////////////////////////////////////////////////////////////////////
	// Settable priorities; fixed ones ignore writes and keep their rank
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < EXC_NUM; i++) begin
				prio_r[i] <= PRIO_RST;
			end
		end else if (cfg_prio_we_i && (cfg_prio_num_i < 6'(EXC_NUM))) begin
			if (EXC_CFG[cfg_prio_num_i]) begin
				prio_r[cfg_prio_num_i] <= cfg_prio_val_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rank per exception: full rank for choice, group rank for preemption
	generate
		for (genvar g = 0; g < EXC_NUM; g++) begin : g_rank
			assign arb.rank[g] = rank_of(6'(g), prio_r[g], 2'h0);
			assign grank_w[g]  = rank_of(6'(g), prio_r[g], subpri_bits_i);
		end
	endgenerate

	assign arb.valid = pend_r;

	prio_pick u_pick (
		.arb (arb)
	);

	////////////////////////////////////////////////////////////////////////
	// Running group rank: most urgent active handler, idle in thread mode
	always_comb begin
		run_grank = RANK_IDLE;
		for (int i = 0; i < EXC_NUM; i++) begin
			if (act_r[i] && (grank_w[i] < run_grank)) begin
				run_grank = grank_w[i];
			end
		end
	end

	assign sel_grank = grank_w[arb.win_num];

	// Strictly more urgent only; an equal group leaves it pending
	assign req_nxt = arb.win_vld && (sel_grank < run_grank);

	////////////////////////////////////////////////////////////////////////
	// Take and completion one-hot vectors
	assign take = req_r && core_ack_i;

	always_comb begin
		take_vec = '0;
		done_vec = '0;
		if (take) begin
			take_vec[num_r] = 1'b1;
		end
		if (exc_done_i && (exc_done_num_i < 6'(EXC_NUM))) begin
			done_vec[exc_done_num_i] = 1'b1;
		end
	end

	// New request beats a take in the same cycle; holes never pend
	assign pend_nxt = (pend_r & ~take_vec) | ({irq_i, sys_pend_i} & EXC_IMPL);
	// A take beats a completion of the same number
	assign act_nxt  = (act_r & ~done_vec) | take_vec;

	////////////////////////////////////////////////////////////////////////
	// Pending state
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	// Active state
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			act_r <= '0;
		end else begin
			act_r <= act_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offer to the core; dropped for one cycle after a take so the
	// next offer is rebuilt from the updated state, never stale
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			req_r <= 1'b0;
		end else if (take) begin
			req_r <= 1'b0;
		end else begin
			req_r <= req_nxt;
		end
	end

	// Winner number and its fetch address; concatenation equals the sum
	// because the base is 256-byte aligned and 4*59 stays below 256
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			num_r <= 6'h00;
			vec_r <= 32'h0000_0000;
		end else begin
			num_r <= arb.win_num;
			vec_r <= {2'b00, vtor_r, arb.win_num, 2'b00};
		end
	end

	assign exc_req_o  = req_r;
	assign exc_num_o  = num_r;
	assign vec_addr_o = vec_r;
	assign pend_o     = pend_r;
	assign active_o   = act_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Helper: a lower number with the winner's rank is also pending
	always_comb begin
		tie_lower = 1'b0;
		for (int i = 0; i < EXC_NUM; i++) begin
			if ((6'(i) < arb.win_num) && pend_r[i] && (arb.rank[i] == arb.win_rank)) begin
				tie_lower = 1'b1;
			end
		end
	end

	sequence s_offer_taken;
		exc_req_o && core_ack_i;
	endsequence

	sequence s_offer_gone;
		!exc_req_o && act_r[$past(exc_num_o)] && !pend_r[$past(exc_num_o)];
	endsequence

	vec_addr_sum_a: assert property (
		exc_req_o && $stable(vtor_r) |-> vec_addr_o == base_w + 32'(exc_num_o) * 32'h4
	) else $error("vector address not base plus four times number");
	late_sys_vec_a: assert property (
		exc_req_o && $stable(vtor_r) && exc_num_o == EXC_PSV |->
			vec_addr_o == base_w + VEC_OFF_PSV
	) else $error("pendable service request vector offset wrong");
	irq_vec_map_a: assert property (
		exc_req_o && $stable(vtor_r) && exc_num_o >= IRQ_BASE |->
			vec_addr_o == base_w + VEC_OFF_IRQ0 + 32'(exc_num_o - IRQ_BASE) * 32'h4
	) else $error("peripheral vector mapping wrong");
	boot_entry_a: assert property (
		boot_sp_addr_o == base_w && boot_pc_addr_o == base_w + VEC_OFF_PC
	) else $error("boot entries not at table start");
	base_reset_a: assert property (
		!$past(rstn_i) |-> vtor_r == VTOR_RST && prio_r[EXC_TICK] == PRIO_RST
	) else $error("base or priority not zero after reset");
	base_write_a: assert property (
		vtor_we_i && vtor_priv_i |=> base_w == {2'b00, $past(vtor_val_i[29:8]), 8'h00}
	) else $error("privileged relocation not taken");
	base_hold_a: assert property (
		vtor_we_i && !vtor_priv_i |=> $stable(vtor_r)
	) else $error("unprivileged relocation took effect");
	fixed_prio_a: assert property (
		cfg_prio_we_i && cfg_prio_num_i == EXC_NMI |=> arb.rank[EXC_NMI] == RANK_NMI
	) else $error("fixed priority altered by write");
	nmi_wins_a: assert property (
		pend_r[EXC_NMI] |-> arb.win_num == EXC_NMI || (pend_r[1] && arb.win_num == 6'h01)
	) else $error("non-maskable interrupt outranked");
	hard_over_cfg_a: assert property (
		pend_r[EXC_HARD] && !pend_r[EXC_NMI] |-> arb.win_num == EXC_HARD
	) else $error("hard fault outranked by settable exception");
	tie_lowest_a: assert property (
		arb.win_vld |-> !tie_lower
	) else $error("tie not broken by lowest number");
	preempt_a: assert property (
		arb.win_vld && sel_grank < run_grank && !take |=> exc_req_o
	) else $error("more urgent exception not offered");
	no_equal_a: assert property (
		arb.win_vld && sel_grank >= run_grank && !take |=> !exc_req_o ##0 pend_r[$past(arb.win_num)]
	) else $error("equal group preempted or lost");
	group_only_a: assert property (
		exc_req_o |-> $past(sel_grank) < $past(run_grank)
	) else $error("offer made without group advantage");
	hole_a: assert property (
		(pend_r & ~EXC_IMPL) == '0 && (!exc_req_o || EXC_IMPL[exc_num_o])
	) else $error("reserved number pending or offered");
	take_seq_a: assert property (
		s_offer_taken |=> s_offer_gone
	) else $error("taken offer not moved to active");

endmodule

// ### hw/prio_pick.sv
// Combinational picker: most urgent valid entry, lowest number on ties.
// Assumes ranks never reach the idle rank for a valid entry.
`timescale 1ns/1ps
module prio_pick
	import exc_pkg::*;
(
	exc_arb_if.pick arb
);

	////////////////////////////////////////////////////////////////////////
	// Scan from the top down so an equal rank lets the lower number win
	always_comb begin
		arb.win_vld  = 1'b0;
		arb.win_num  = 6'h00;
		arb.win_rank = RANK_IDLE;
		for (int i = EXC_NUM - 1; i >= 0; i--) begin
			if (arb.valid[i] && (arb.rank[i] <= arb.win_rank)) begin
				arb.win_vld  = 1'b1;
				arb.win_num  = 6'(i);
				arb.win_rank = arb.rank[i];
			end
		end
	end

endmodule

// ### pkg/exc_arb_if.sv
// Carrier between the priority logic and its minimum-rank picker.
// Assumes the picker is purely combinational.
`timescale 1ns/1ps
interface exc_arb_if #(
	parameter int unsigned N = 60
);
	logic [N-1:0] valid;
	logic [3:0]   rank [N];
	logic         win_vld;
	logic [5:0]   win_num;
	logic [3:0]   win_rank;

	modport owner (output valid, output rank, input win_vld, input win_num, input win_rank);
	modport pick  (input valid, input rank, output win_vld, output win_num, output win_rank);
endinterface

// ### pkg/exc_pkg.sv
// Constants shared by the exception priority and vector logic.
// Assumes one 50 MHz system clock and a fixed set of 60 exception numbers.
package exc_pkg;

	// Exception number space
	localparam int unsigned EXC_NUM   = 60;
	localparam int unsigned IRQ_NUM   = 44;
	localparam int unsigned SYS_NUM   = 16;
	localparam logic [5:0]  IRQ_BASE  = 6'h10;
	localparam logic [5:0]  EXC_NMI   = 6'h02;
	localparam logic [5:0]  EXC_HARD  = 6'h03;
	localparam logic [5:0]  EXC_PSV   = 6'h0e;
	localparam logic [5:0]  EXC_TICK  = 6'h0f;

	// Vector offsets of the two late system entries, of the first peripheral and of the boot code entry
	localparam logic [31:0] VEC_OFF_PSV  = 32'h0000_0038;
	localparam logic [31:0] VEC_OFF_TICK = 32'h0000_003c;
	localparam logic [31:0] VEC_OFF_IRQ0 = 32'h0000_0040;
	localparam logic [31:0] VEC_OFF_PC   = 32'h0000_0004;

	// Implemented peripheral lines; 6,8,26,27,33,34,37,38,40,41 are holes
	localparam logic [IRQ_NUM-1:0] IRQ_IMPL = 44'hc99_f3ff_febf;
	// Implemented system numbers: 2..6, 11, 12, 14, 15
	localparam logic [SYS_NUM-1:0] SYS_IMPL = 16'hd87c;
	localparam logic [EXC_NUM-1:0] EXC_IMPL = {IRQ_IMPL, SYS_IMPL};
	// Numbers whose priority software may set (implemented ones except NMI and hard fault)
	localparam logic [EXC_NUM-1:0] EXC_CFG  = EXC_IMPL & ~60'h0c;

	// Priority ranks: smaller is more urgent; reset -3, NMI -2, hard -1
	localparam logic [3:0] RANK_RESET = 4'h0;
	localparam logic [3:0] RANK_NMI   = 4'h1;
	localparam logic [3:0] RANK_HARD  = 4'h2;
	localparam logic [3:0] RANK_CFG0  = 4'h3;
	localparam logic [3:0] RANK_IDLE  = 4'hf;

	// Reset values
	localparam logic [2:0]  PRIO_RST = 3'h0;
	localparam logic [21:0] VTOR_RST = 22'h0;

endpackage

// ### tb/core_model.sv
// Behavioural stand-in for the processor core on the offer side.
// Assumes the bench enables taking and requests completions.
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// Bench control
	input  wire logic       ack_en_i,
	input  wire logic [3:0] ack_dly_i,
	input  wire logic       done_go_i,
	input  wire logic [5:0] done_num_i,
	// Offer side
	input  wire logic       exc_req_i,
	output logic            core_ack_o,
	output logic            exc_done_o,
	output logic [5:0]      exc_done_num_o
);
	logic [3:0] wait_r;

	////////////////////////////////////////////////////////////////
	// Take an offer after a set delay; once only, since the offer drops
	always_ff @(posedge sys_clk_i) begin
		core_ack_o <= 1'b0;
		wait_r     <= (exc_req_i && !core_ack_o) ? wait_r + 4'h1 : 4'h0;
		if (!rstn_i) begin
			wait_r <= 4'h0;
		end else if (ack_en_i && exc_req_i && !core_ack_o && wait_r >= ack_dly_i) begin
			core_ack_o <= 1'b1;
		end
	end

	// Handler completion, one cycle after the bench asks
	always_ff @(posedge sys_clk_i) begin
		exc_done_o     <= rstn_i & done_go_i;
		exc_done_num_o <= done_num_i;
	end
endmodule

// ### tb/exception_priority_vector_logic_tb_top.sv
// Self-checking bench for the exception priority and vector logic.
// Assumes a core model that takes offers only while enabled.
`timescale 1ns/1ps
module exception_priority_vector_logic_tb_top;
	import exc_pkg::*;
	logic                sys_clk_i = 1'b0;
	logic                rstn_i = 1'b0;
	logic [IRQ_NUM-1:0]  irq_i = '0;
	logic [SYS_NUM-1:0]  sys_pend_i = '0;
	logic                we = 1'b0, vwe = 1'b0, vpriv = 1'b0, ack_en = 1'b0, done_go = 1'b0;
	logic [5:0]          pnum = '0, done_num = '0;
	logic [2:0]          pval = '0;
	logic [1:0]          subpri = '0;
	logic [3:0]          ack_dly = '0;
	logic [31:0]         vval = '0, vb = '0;
	logic                ack, done;
	logic [5:0]          dnum;
	logic                exc_req_o;
	logic [5:0]          exc_num_o;
	logic [31:0]         vec_addr_o, boot_sp_addr_o, boot_pc_addr_o, vbase;
	logic [EXC_NUM-1:0]  pend_o, active_o;
	int                  fail_count = 0;
	int                  compares = 0;

	always #10 sys_clk_i = ~sys_clk_i;

	exception_priority_vector_logic i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.irq_i(irq_i), .sys_pend_i(sys_pend_i), .cfg_prio_we_i(we), .cfg_prio_num_i(pnum),
		.cfg_prio_val_i(pval), .subpri_bits_i(subpri), .vtor_we_i(vwe), .vtor_priv_i(vpriv),
		.vtor_val_i(vval), .core_ack_i(ack), .exc_done_i(done), .exc_done_num_i(dnum),
		.exc_req_o(exc_req_o), .exc_num_o(exc_num_o), .vec_addr_o(vec_addr_o),
		.boot_sp_addr_o(boot_sp_addr_o), .boot_pc_addr_o(boot_pc_addr_o),
		.vector_base_offset_reg_o(vbase), .pend_o(pend_o), .active_o(active_o));

	core_model i_core (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ack_en_i(ack_en),
		.ack_dly_i(ack_dly), .done_go_i(done_go), .done_num_i(done_num),
		.exc_req_i(exc_req_o), .core_ack_o(ack), .exc_done_o(done), .exc_done_num_o(dnum));

	////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %0h", $time, m, got);
		end
	endtask

	task automatic pulse(input logic [IRQ_NUM-1:0] p, input logic [SYS_NUM-1:0] s);
		@(posedge sys_clk_i) begin irq_i <= p; sys_pend_i <= s; end
		@(posedge sys_clk_i) begin irq_i <= '0; sys_pend_i <= '0; end
	endtask

	task automatic prio(input logic [5:0] n, input logic [2:0] v);
		@(posedge sys_clk_i) begin we <= 1'b1; pnum <= n; pval <= v; end
		@(posedge sys_clk_i) we <= 1'b0;
	endtask

	// Bounded wait, so a missing offer is reported rather than hung on
	task automatic offer(input logic [5:0] n);
		int i;
		i = 0;
		while (exc_req_o !== 1'b1 && i < 20) begin
			@(negedge sys_clk_i);
			i++;
		end
		chk(64'(exc_req_o), 64'h1, "no offer");
		chk(64'(exc_num_o), 64'(n), "offer number");
		chk(64'(vec_addr_o), 64'(vb + {24'h0, n, 2'b00}), "vector address");
		// Word-aligned entry, so the two low bits of its address are zero
		chk(64'(vec_addr_o[1:0]), 64'h0, "vector entry alignment");
	endtask

	task automatic take(input logic [5:0] n);
		int i;
		i = 0;
		@(posedge sys_clk_i) ack_en <= 1'b1;
		while (active_o[n] !== 1'b1 && i < 20) begin
			@(negedge sys_clk_i);
			i++;
		end
		@(posedge sys_clk_i) ack_en <= 1'b0;
		@(negedge sys_clk_i);
		chk(64'({active_o[n], pend_o[n]}), 64'h2, "take state");
	endtask

	task automatic fin(input logic [5:0] n);
		@(posedge sys_clk_i) begin done_go <= 1'b1; done_num <= n; end
		@(posedge sys_clk_i) done_go <= 1'b0;
		repeat (3) @(negedge sys_clk_i);
	endtask

	task automatic quiet(input string m);
		repeat (5) @(negedge sys_clk_i);
		chk(64'(exc_req_o), 64'h0, m);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_reset();
		chk(64'(vbase), 64'h0, "base after reset");
		chk(64'({boot_sp_addr_o, boot_pc_addr_o}), 64'h4, "boot entries");
		chk(64'(pend_o | active_o), 64'h0, "state after reset");
	endtask

	// Equal default priorities: lowest number first, no equal preemption
	task automatic s_tie();
		pulse(44'h3, '0);
		offer(6'h10);
		take(6'h10);
		chk(64'(pend_o[17]), 64'h1, "still pending");
		quiet("equal priority offered");
		fin(6'h10);
		offer(6'h11);
		take(6'h11);
		fin(6'h11);
	endtask

	task automatic s_resv();
		pulse(44'h140, 16'h0102);
		// Pending bits settle after the pulse edge, so look off the edge
		@(negedge sys_clk_i);
		chk(64'(pend_o), 64'h0, "reserved pended");
		quiet("reserved offered");
	endtask

	task automatic s_prio();
		prio(6'h10, 3'h7);
		prio(6'h11, 3'h1);
		prio(6'h02, 3'h7);
		pulse(44'h3, '0);
		offer(6'h11);
		take(6'h11);
		pulse(44'h4, '0);
		offer(6'h12);
		ack_dly <= 4'h3;
		take(6'h12);
		pulse('0, 16'h0004);
		offer(EXC_NMI);
		take(EXC_NMI);
		ack_dly <= 4'h0;
		fin(EXC_NMI);
		quiet("lower priority preempted");
		fin(6'h12);
		fin(6'h11);
		offer(6'h10);
		take(6'h10);
		fin(6'h10);
	endtask

	// One subpriority bit: 2 and 3 share a group; the arrival has the
	// better full priority, so only group-only preemption keeps it out
	task automatic s_group();
		subpri <= 2'h1;
		prio(6'h10, 3'h2);
		prio(6'h11, 3'h3);
		pulse(44'h2, '0);
		offer(6'h11);
		take(6'h11);
		pulse(44'h1, '0);
		quiet("same group preempted");
		fin(6'h11);
		offer(6'h10);
		take(6'h10);
		fin(6'h10);
		subpri <= 2'h0;
	endtask

	task automatic s_vtor();
		@(posedge sys_clk_i) begin vwe <= 1'b1; vval <= 32'h0000_0400; end
		@(posedge sys_clk_i) vwe <= 1'b0;
		repeat (3) @(negedge sys_clk_i);
		chk(64'(vbase), 64'h0, "unprivileged write");
		for (int k = 0; k < 2; k++) begin
			vb = k ? 32'h3fff_ff00 : 32'h0000_0100;
			@(posedge sys_clk_i) begin vwe <= 1'b1; vpriv <= 1'b1; vval <= vb; end
			@(posedge sys_clk_i) begin vwe <= 1'b0; vpriv <= 1'b0; end
			repeat (3) @(negedge sys_clk_i);
			chk(64'({vbase, boot_pc_addr_o}), 64'({vb, vb + 32'h4}), "relocated base");
			pulse('0, k ? 16'h4000 : 16'h8000);
			offer(k ? EXC_PSV : EXC_TICK);
			take(k ? EXC_PSV : EXC_TICK);
			fin(k ? EXC_PSV : EXC_TICK);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict and run control
	task automatic results();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Whole sequence needs well under 2000 cycles
	initial begin
		#200000;
		fail_count++;
		results();
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		s_reset();
		s_tie();
		s_resv();
		s_prio();
		s_group();
		s_vtor();
		results();
	end
endmodule
